// [hw/cal_ctrl_pkg.sv]
// package: register map, field layout, reset values and types of the calibration control bank
package cal_ctrl_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_INPUT_SEL = 8'h60;
  localparam logic [7:0] OFS_RUN       = 8'h61;
  localparam logic [7:0] OFS_MODE      = 8'h62;
  localparam logic [7:0] OFS_CORE      = 8'h64;
  localparam logic [7:0] OFS_AVG       = 8'h68;
  localparam logic [7:0] OFS_STATUS    = 8'h6A;
  // ==========================================================
  // field positions
  localparam int BIT_SWAP     = 4;
  localparam int BIT_RUN      = 0;
  localparam int BIT_BGOS     = 3;
  localparam int BIT_FGOS     = 2;
  localparam int BIT_BG       = 1;
  localparam int BIT_FG       = 0;
  localparam int BIT_FOREGROUND_FINISHED  = 0;
  localparam int BIT_STOPPED  = 1;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_INPUT_SEL = 8'h01;
  localparam logic [7:0] RST_RUN       = 8'h01;
  localparam logic [7:0] RST_MODE      = 8'h01;
  localparam logic [7:0] RST_CORE      = 8'h01;
  localparam logic [7:0] RST_AVG       = 8'h61;
  // register write masks (reserved bits stay zero)
  localparam logic [7:0] MSK_INPUT_SEL = 8'h13;
  localparam logic [7:0] MSK_RUN       = 8'h01;
  localparam logic [7:0] MSK_MODE      = 8'h0F;
  localparam logic [7:0] MSK_CORE      = 8'h03;
  localparam logic [7:0] MSK_AVG       = 8'h77;
  // ==========================================================
  // timing: base calibration pass length in cycles, scaled by averaging
  localparam logic [15:0] CAL_BASE_CYC = 16'h0010;
  localparam logic [2:0]  DIV_RATIO    = 3'h3;
  // ==========================================================
  // types
  typedef enum logic [1:0] {CAL_HOLD, FOREGROUND_CAL_ON_RUN, BACKGROUND_CAL_ON_RUN, CAL_IDLE} cal_state_e;
  typedef struct packed {
    logic [7:0] input_sel;
    logic [7:0] run;
    logic [7:0] mode;
    logic [7:0] core;
    logic [7:0] avg;
  } regs_s;
  typedef struct packed {
    logic       sel_a_b;   // channel a sampling input b
    logic       sel_b_b;   // channel b sampling input b
  } mux_s;
endpackage

// [hw/cal_ctrl.sv]
// module: input mux and calibration control register bank with calibration sequencer
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
// Notes on behaviour
// [RQ1] swap bit exchanges channel inputs
// [RQ2] swap ignored in single-channel modes
// [RQ3] single input field picks sampled input
// [RQ4] single input field ignored in dual modes
// [RQ5] new mux setting applied at calibration
// [RQ6] run bit clear holds calibration reset
// [RQ7] run clear also resets clock dividers
// [RQ8] software reprograms only while run clear
// [RQ9] run set before link enable
// [RQ10] background offset needs background on
// [RQ11] foreground offset needs foreground on
// [RQ12] background calibration bit enables background
// [RQ13] foreground bit runs or skips foreground
// [RQ14] idle core field disables one core
// [RQ15] core field written only link off
// [RQ16] averaging register fields and reset
// [RQ17] larger averaging means longer calibration
// [RQ18] foreground finished flag after done/skip
module cal_ctrl (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       LINK_SINGLE,   // link mode selects single-channel
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            CHA_SAMPLES_B,
  output logic            CHB_SAMPLES_B,
  output logic            CAL_RUNNING,
  output logic            BG_CAL_ACTIVE,
  output logic            BG_OFS_ACTIVE,
  output logic            FG_OFS_ACTIVE,
  output logic      [1:0] IDLE_CORE,
  output logic            DIV_RST_N,
  output logic            DIG_CLK_EN,
  output logic            LINK_CLK_EN
);
  // ==========================================================
  // state
  typedef struct packed {
    cal_ctrl_pkg::regs_s      regs;
    cal_ctrl_pkg::cal_state_e st;
    logic [15:0]              cnt;       // foreground pass countdown
    logic                     foreground_finished;
    cal_ctrl_pkg::mux_s       mux;       // applied mux, updated at calibration
    logic [2:0]               div;       // clock divider shared by digital and link enables
    logic [7:0]               rdata;
    logic                     bg_act;
    logic                     bgos_act;
    logic                     fgos_act;
    logic                     div_rst_n;
    logic                     running;   // foreground pass busy, registered decode
    logic                     clk_en;    // divided clock enable, registered decode
  } state_s;

  state_s cur_ff;   // registered state
  state_s nxt_st;   // next state

  // mux decode from the input selection and link mode
  function automatic cal_ctrl_pkg::mux_s decode_mux(input logic [7:0] sel, input logic single);
    cal_ctrl_pkg::mux_s m;
    m = '0;
    if (single) begin
      // [RQ3] single mode pick
      // [RQ2] swap bit ignored here
      unique case (sel[1:0])
        2'h2:    begin m.sel_a_b = 1'b1; m.sel_b_b = 1'b1; end
        2'h3:    begin m.sel_a_b = 1'b0; m.sel_b_b = 1'b1; end
        default: begin m.sel_a_b = 1'b0; m.sel_b_b = 1'b0; end  // 1 and reserved 0 use input a
      endcase
    end else begin
      // [RQ1] dual mode swap
      // [RQ4] single field ignored here
      m.sel_a_b = sel[cal_ctrl_pkg::BIT_SWAP];
      m.sel_b_b = ~sel[cal_ctrl_pkg::BIT_SWAP];
    end
    return m;
  endfunction

  // pass length grows with both averaging depths
  function automatic logic [15:0] pass_len(input logic [7:0] avg);
    logic [15:0] n;
    n = cal_ctrl_pkg::CAL_BASE_CYC;
    n = n << avg[6:4];
    n = n + (cal_ctrl_pkg::CAL_BASE_CYC << avg[2:0]);
    return n;
  endfunction

  logic run_bit;   // calibration run control
  assign run_bit = cur_ff.regs.run[cal_ctrl_pkg::BIT_RUN];

  // ==========================================================
  // next-state logic
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.rdata = 8'h00;
    // register writes; reserved bits masked to zero
    if (WR) begin
      unique case (ADDR)
        cal_ctrl_pkg::OFS_INPUT_SEL: nxt_st.regs.input_sel = WDATA & cal_ctrl_pkg::MSK_INPUT_SEL;
        cal_ctrl_pkg::OFS_RUN:       nxt_st.regs.run = WDATA & cal_ctrl_pkg::MSK_RUN;
        cal_ctrl_pkg::OFS_MODE:      nxt_st.regs.mode = WDATA & cal_ctrl_pkg::MSK_MODE;
        // [RQ15] link-off writes assumed by software
        cal_ctrl_pkg::OFS_CORE:      nxt_st.regs.core = WDATA & cal_ctrl_pkg::MSK_CORE;
        // [RQ16] averaging fields stored
        cal_ctrl_pkg::OFS_AVG:       nxt_st.regs.avg = WDATA & cal_ctrl_pkg::MSK_AVG;
        default: ;   // unmapped writes dropped
      endcase
    end
    // register reads, data one cycle later; unmapped read as zero
    if (RD) begin
      unique case (ADDR)
        cal_ctrl_pkg::OFS_INPUT_SEL: nxt_st.rdata = cur_ff.regs.input_sel;
        cal_ctrl_pkg::OFS_RUN:       nxt_st.rdata = cur_ff.regs.run;
        cal_ctrl_pkg::OFS_MODE:      nxt_st.rdata = cur_ff.regs.mode;
        cal_ctrl_pkg::OFS_CORE:      nxt_st.rdata = cur_ff.regs.core;
        cal_ctrl_pkg::OFS_AVG:       nxt_st.rdata = cur_ff.regs.avg;
        cal_ctrl_pkg::OFS_STATUS: begin
          // [RQ18] finished flag readback
          nxt_st.rdata[cal_ctrl_pkg::BIT_FOREGROUND_FINISHED] = cur_ff.foreground_finished;
          nxt_st.rdata[cal_ctrl_pkg::BIT_STOPPED] =
            cur_ff.foreground_finished & ~cur_ff.regs.mode[cal_ctrl_pkg::BIT_BG];
        end
        default: nxt_st.rdata = 8'h00;
      endcase
    end
    // ---- dividers: held in reset while run bit is clear
    // [RQ7] run clear resets dividers
    nxt_st.div_rst_n = run_bit;
    if (!run_bit) begin
      nxt_st.div = 3'h0;
    end else if (cur_ff.div == cal_ctrl_pkg::DIV_RATIO) begin
      nxt_st.div = 3'h0;
    end else begin
      nxt_st.div = cur_ff.div + 3'h1;
    end
    // ---- calibration sequencer
    unique case (cur_ff.st)
      cal_ctrl_pkg::CAL_HOLD: begin
        // [RQ6] held in reset while run clear
        nxt_st.foreground_finished = 1'b0;
        nxt_st.bg_act = 1'b0;
        nxt_st.bgos_act = 1'b0;
        nxt_st.fgos_act = 1'b0;
        if (run_bit) begin
          // [RQ5] mux setting applied at start
          nxt_st.mux = decode_mux(cur_ff.regs.input_sel, LINK_SINGLE);
          // [RQ13] values reset, then run or skip
          if (cur_ff.regs.mode[cal_ctrl_pkg::BIT_FG]) begin
            // [RQ17] depth scales pass length
            nxt_st.cnt = pass_len(cur_ff.regs.avg);
            // [RQ11] offset only with foreground
            nxt_st.fgos_act = cur_ff.regs.mode[cal_ctrl_pkg::BIT_FGOS];
            nxt_st.st = cal_ctrl_pkg::FOREGROUND_CAL_ON_RUN;
          end else begin
            nxt_st.foreground_finished = 1'b1;
            nxt_st.st = cal_ctrl_pkg::CAL_IDLE;
          end
        end
      end
      cal_ctrl_pkg::FOREGROUND_CAL_ON_RUN: begin
        if (!run_bit) begin
          // abort drops the offset pass at once, not a cycle later in hold
          nxt_st.fgos_act = 1'b0;
          nxt_st.st = cal_ctrl_pkg::CAL_HOLD;
        end else if (cur_ff.cnt == 16'h0000) begin
          nxt_st.foreground_finished = 1'b1;
          nxt_st.fgos_act = 1'b0;
          nxt_st.st = cal_ctrl_pkg::CAL_IDLE;
        end else begin
          nxt_st.cnt = cur_ff.cnt - 16'h0001;
        end
      end
      cal_ctrl_pkg::CAL_IDLE, cal_ctrl_pkg::BACKGROUND_CAL_ON_RUN: begin
        if (!run_bit) begin
          nxt_st.st = cal_ctrl_pkg::CAL_HOLD;
        end else begin
          // [RQ12] background follows its bit
          nxt_st.bg_act = cur_ff.regs.mode[cal_ctrl_pkg::BIT_BG];
          // [RQ10] offset only with background
          nxt_st.bgos_act = cur_ff.regs.mode[cal_ctrl_pkg::BIT_BG]
                          & cur_ff.regs.mode[cal_ctrl_pkg::BIT_BGOS];
          nxt_st.st = cur_ff.regs.mode[cal_ctrl_pkg::BIT_BG] ?
                      cal_ctrl_pkg::BACKGROUND_CAL_ON_RUN : cal_ctrl_pkg::CAL_IDLE;
        end
      end
    endcase
    // decodes of the next state, so every output leaves a flop
    nxt_st.running = (nxt_st.st == cal_ctrl_pkg::FOREGROUND_CAL_ON_RUN);
    nxt_st.clk_en = nxt_st.div_rst_n & (nxt_st.div == 3'h0);
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur_ff <= '{regs: '{input_sel: cal_ctrl_pkg::RST_INPUT_SEL,
                          run:       cal_ctrl_pkg::RST_RUN,
                          mode:      cal_ctrl_pkg::RST_MODE,
                          core:      cal_ctrl_pkg::RST_CORE,
                          avg:       cal_ctrl_pkg::RST_AVG},
                  st: cal_ctrl_pkg::CAL_HOLD,
                  default: '0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign RDATA = cur_ff.rdata;
  assign CHA_SAMPLES_B = cur_ff.mux.sel_a_b;
  assign CHB_SAMPLES_B = cur_ff.mux.sel_b_b;
  assign CAL_RUNNING = cur_ff.running;
  assign BG_CAL_ACTIVE = cur_ff.bg_act;
  assign BG_OFS_ACTIVE = cur_ff.bgos_act;
  assign FG_OFS_ACTIVE = cur_ff.fgos_act;
  // [RQ14] idle core field driven out whatever the background bit
  assign IDLE_CORE = cur_ff.regs.core[1:0];
  assign DIV_RST_N = cur_ff.div_rst_n;
  assign DIG_CLK_EN = cur_ff.clk_en;
  assign LINK_CLK_EN = cur_ff.clk_en;

  // ==========================================================
  // checks
  AST_DIV_HOLD: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ7]
    !run_bit |=> !DIV_RST_N)
    else $error("dividers not held with run clear");
  AST_HOLD_CLEARS: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ6]
    !run_bit ##1 !run_bit |=> !CAL_RUNNING && !BG_CAL_ACTIVE)
    else $error("calibration active while held");
  AST_BGOS: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ10]
    BG_OFS_ACTIVE |-> BG_CAL_ACTIVE)
    else $error("background offset without background");
  AST_FGOS: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ11]
    FG_OFS_ACTIVE |-> CAL_RUNNING)
    else $error("foreground offset outside foreground");
  AST_SKIP: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ13]
    (cur_ff.st == cal_ctrl_pkg::CAL_HOLD && run_bit && !cur_ff.regs.mode[0])
      |=> cur_ff.foreground_finished && !CAL_RUNNING)
    else $error("skip did not finish foreground");
  AST_DONE_FLAG: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ18]
    CAL_RUNNING && cur_ff.cnt == 16'h0000 && run_bit |=> cur_ff.foreground_finished)
    else $error("foreground finished not raised");
  AST_SWAP: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ1]
    (cur_ff.st == cal_ctrl_pkg::CAL_HOLD && run_bit && !LINK_SINGLE)
      |=> CHA_SAMPLES_B == $past(cur_ff.regs.input_sel[4]) && CHB_SAMPLES_B != CHA_SAMPLES_B)
    else $error("swap not applied");
  AST_MUX_STABLE: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ5]
    cur_ff.st != cal_ctrl_pkg::CAL_HOLD |=> $stable(CHA_SAMPLES_B) && $stable(CHB_SAMPLES_B))
    else $error("mux changed without calibration");
  AST_READ: assert property (@(posedge CLK) disable iff (!RSTN) // [RQ16]
    RD && !WR && ADDR == cal_ctrl_pkg::OFS_AVG |=> RDATA == $past(cur_ff.regs.avg))
    else $error("averaging readback wrong");
endmodule

// [bench/cal_ctrl_bench.sv]
// testbench: register access, input mux and calibration sequencing checks of cal_ctrl
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("ERROR %0t: got %0h expected %0h", $time, (g), (e)); end end
module cal_ctrl_bench;
  // ==========================================================
  // signals
  logic       CLK;           // 125 MHz clock
  logic       RSTN;          // async reset, active low
  logic       LINK_SINGLE;   // single-channel link mode
  logic [7:0] ADDR;          // register address
  logic [7:0] WDATA;         // write data
  logic       WR;            // write strobe
  logic       RD;            // read strobe
  logic [7:0] RDATA;         // read data, one cycle after the strobe
  logic       CHA_SAMPLES_B; // channel a on input b
  logic       CHB_SAMPLES_B; // channel b on input b
  logic       CAL_RUNNING;   // foreground pass busy
  logic       BG_CAL_ACTIVE; // background calibration on
  logic       BG_OFS_ACTIVE; // background offset on
  logic       FG_OFS_ACTIVE; // foreground offset on
  logic [1:0] IDLE_CORE;     // idle core choice
  logic       DIV_RST_N;     // divider reset, active low
  logic       DIG_CLK_EN;    // digital block clock enable
  logic       LINK_CLK_EN;   // link clock enable
  int         errors;        // mismatches seen
  int         tests_run;     // comparisons made
  logic [7:0] v;             // last read value
  int         n0;            // short pass length
  int         n1;            // long pass length
  int         nd;            // digital enable pulses
  int         nl;            // link enable pulses
  logic       pa;            // channel a state after last calibration
  logic       pb;            // channel b state after last calibration
  // mux cases: link single, select value, expected a on b, expected b on b
  logic [10:0] mux_tab [7] = '{11'h005, 11'h046, 11'h04A, 11'h404, 11'h44B, 11'h44D, 11'h440};

  cal_ctrl DUT (.CLK(CLK), .RSTN(RSTN), .LINK_SINGLE(LINK_SINGLE), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CHA_SAMPLES_B(CHA_SAMPLES_B), .CHB_SAMPLES_B(CHB_SAMPLES_B),
    .CAL_RUNNING(CAL_RUNNING), .BG_CAL_ACTIVE(BG_CAL_ACTIVE), .BG_OFS_ACTIVE(BG_OFS_ACTIVE),
    .FG_OFS_ACTIVE(FG_OFS_ACTIVE), .IDLE_CORE(IDLE_CORE), .DIV_RST_N(DIV_RST_N),
    .DIG_CLK_EN(DIG_CLK_EN), .LINK_CLK_EN(LINK_CLK_EN));

  // ==========================================================
  // clock and watchdog
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // whole run is some two thousand cycles, so 50k cycles means a hang
  initial begin
    #400000;
    errors++;
    end_sim();
  end

  // ==========================================================
  // bus tasks: one-cycle strobes launched right after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdv(a, d);
    `CHK(d, e)
  endtask
  // poll status until the foreground finished bit shows, bounded
  task automatic wait_done();
    for (int i = 0; i < 2000; i++) begin
      rdv(cal_ctrl_pkg::OFS_STATUS, v);
      if (v[cal_ctrl_pkg::BIT_FOREGROUND_FINISHED] === 1'b1) break;
    end
    `CHK(v[cal_ctrl_pkg::BIT_FOREGROUND_FINISHED], 1'b1)
  endtask
  // rerun calibration and count the busy cycles of the pass
  task automatic cal_len(output int n);
    wr(cal_ctrl_pkg::OFS_RUN, 8'h00);
    wr(cal_ctrl_pkg::OFS_RUN, 8'h01);
    n = 0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge CLK);
      #1;
      if (CAL_RUNNING === 1'b1) n++;
      else if (n > 0) break;
    end
  endtask
  // count clock enable pulses over eight cycles
  task automatic count_en();
    nd = 0;
    nl = 0;
    repeat (8) begin
      @(posedge CLK);
      #1;
      if (DIG_CLK_EN === 1'b1) nd++;
      if (LINK_CLK_EN === 1'b1) nl++;
    end
  endtask
  task automatic end_sim();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {RSTN, LINK_SINGLE, ADDR, WDATA, WR, RD, errors, tests_run} = '0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    // reset values and unmapped address
    rd(cal_ctrl_pkg::OFS_INPUT_SEL, 8'h01);
    rd(cal_ctrl_pkg::OFS_RUN, 8'h01);
    rd(cal_ctrl_pkg::OFS_MODE, 8'h01);
    rd(cal_ctrl_pkg::OFS_CORE, 8'h01);
    rd(cal_ctrl_pkg::OFS_AVG, 8'h61);
    rd(8'h70, 8'h00);
    wait_done();
    `CHK({CHA_SAMPLES_B, CHB_SAMPLES_B}, 2'b01)
    // reserved bits read back as zero
    wr(cal_ctrl_pkg::OFS_AVG, 8'hFF);
    rd(cal_ctrl_pkg::OFS_AVG, 8'h77);
    // link stays off in this bench, so core writes are legal
    wr(cal_ctrl_pkg::OFS_CORE, 8'h02);
    rd(cal_ctrl_pkg::OFS_CORE, 8'h02);
    `CHK(IDLE_CORE, 2'h2)
    // larger averaging means a longer pass
    // each pass reruns via run clear then run set
    wr(cal_ctrl_pkg::OFS_AVG, 8'h00);
    cal_len(n0);
    wr(cal_ctrl_pkg::OFS_AVG, 8'h11);
    cal_len(n1);
    `CHK(n1 > n0, 1'b1)
    // run clear holds dividers, run set restarts the enables
    // output link never enabled, run may toggle freely
    wr(cal_ctrl_pkg::OFS_RUN, 8'h00);
    repeat (2) @(posedge CLK);
    #1 `CHK(DIV_RST_N, 1'b0)
    count_en();
    `CHK(nd + nl, 0)
    wr(cal_ctrl_pkg::OFS_RUN, 8'h01);
    repeat (3) @(posedge CLK);
    count_en();
    `CHK(nd, 2)
    `CHK(nl, 2)
    wait_done();
    // input mux cases, applied only at a calibration start
    pa = 1'b0;
    pb = 1'b1;
    foreach (mux_tab[k]) begin
      // run cleared before the selection changes
      wr(cal_ctrl_pkg::OFS_RUN, 8'h00);
      LINK_SINGLE <= mux_tab[k][10];
      wr(cal_ctrl_pkg::OFS_INPUT_SEL, mux_tab[k][9:2]);
      repeat (3) @(posedge CLK);
      #1 `CHK({CHA_SAMPLES_B, CHB_SAMPLES_B}, {pa, pb})
      wr(cal_ctrl_pkg::OFS_RUN, 8'h01);
      repeat (4) @(posedge CLK);
      #1 `CHK({CHA_SAMPLES_B, CHB_SAMPLES_B}, mux_tab[k][1:0])
      {pa, pb} = mux_tab[k][1:0];
      wait_done();
    end
    // foreground offset during a pass, status clear until finished
    wr(cal_ctrl_pkg::OFS_RUN, 8'h00);
    wr(cal_ctrl_pkg::OFS_MODE, 8'h05);
    wr(cal_ctrl_pkg::OFS_RUN, 8'h01);
    repeat (4) @(posedge CLK);
    #1 `CHK({CAL_RUNNING, FG_OFS_ACTIVE}, 2'b11)
    rd(cal_ctrl_pkg::OFS_STATUS, 8'h00);
    wait_done();
    // mode table: foreground skipped, background bits and offset gating
    for (int k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h0A : (k == 1) ? 8'h08 : 8'h04;
      wr(cal_ctrl_pkg::OFS_RUN, 8'h00);
      wr(cal_ctrl_pkg::OFS_MODE, v);
      wr(cal_ctrl_pkg::OFS_RUN, 8'h01);
      repeat (4) @(posedge CLK);
      #1 `CHK({BG_CAL_ACTIVE, BG_OFS_ACTIVE}, {2{k == 0}})
      `CHK(FG_OFS_ACTIVE, 1'b0)
      `CHK(CAL_RUNNING, 1'b0)
    end
    rd(cal_ctrl_pkg::OFS_STATUS, 8'h03);
    end_sim();
  end
endmodule
